// ### hw/rbs_map.vh
`ifndef RBS_MAP_VH
`define RBS_MAP_VH

// reset cause codes
`define RBS_CAUSE_NONE 3'h0
`define RBS_CAUSE_POR 3'h1
`define RBS_CAUSE_PIN 3'h2
`define RBS_CAUSE_WDOG 3'h3
`define RBS_CAUSE_WAKE 3'h4
`define RBS_CAUSE_BROWN 3'h5

// start mode codes
`define RBS_MODE_USER 2'h0
`define RBS_MODE_LOADER 2'h1
`define RBS_MODE_DEBUG 2'h2
`define RBS_MODE_HOTJTAG 2'h3

// program counter start value
`define RBS_PC_START 16'h0000

// pin reset minimum low time
`define RBS_PIN_LOW_NS 100
`define RBS_CLK_NS 50
`define RBS_PIN_LOW_CYC ((`RBS_PIN_LOW_NS + `RBS_CLK_NS - 1) / `RBS_CLK_NS)

// hold count; the internal reset is held 10 cycles after all sources go away
`define RBS_HOLD_CYC 4'h8

`endif

// ### hw/rbs_reset_boot.v
`timescale 1ns/10ps
`include "rbs_map.vh"

// Behaviour
// R01: five reset sources recognised separately
// R02: boot choice latched until power-on/pin reset
// R03: boot pins, TMS, strap select start mode
// R04: boot high, TMS low: user mode
// R05: boot low, TMS low: loader mode
// R06: boot low, TMS high, strap low: debug (code gives flagged user mode instead when FLASH_PROTECTED is high)
// R07: boot high, TMS high, strap low: hot-attach
// R08: board holds reset pin low >=100 ns
// R09: pin reset accepted also in power-down
// R10: watchdog timeout resets the whole device (code keeps OSC_PLL_RESET low, leaving the oscillator and PLL running)
// R11: RAM kept except power-on/brownout reset
// R12: wake-up restores regulator; watchdog leaves it
// R13: active: both regulators; power-down: low-power only
// R14: pin synchronised; power-on/brownout take precedence
module rbs_reset_boot (
    // clock and reset
    input wire CORE_CLK,
    input wire RST,
    // reset sources
    input wire POR_DET,
    input wire RESET_PIN_N,
    input wire WATCHDOG_TIMER_TIMEOUT,
    input wire WAKEUP_EVENT,
    input wire BROWNOUT_DET,
    // power state from the power manager
    input wire POWERDOWN_REQ,
    // boot straps
    input wire BOOT_MODE_PIN,
    input wire JTAG_TMS,
    input wire CLOCK_OUT_BOOT_STRAP,
    input wire FLASH_PROTECTED,
    // reset outputs
    output reg SYS_RESET,
    output reg [2:0] RESET_CAUSE,
    output reg RAM_CONTENT_VALID,
    output reg OSC_PLL_RESET,
    // regulator control
    output reg MAIN_REG_EN,
    output reg LP_REG_EN,
    // boot result
    output reg [1:0] START_MODE,
    output reg STRAP_INVALID,
    output reg JTAG_PINS_ACTIVE,
    output reg [15:0] PC_START
);

    // three flops for the reset pin, two-flop synchronisers for the other reset sources, the straps and power-down; FLASH_PROTECTED is not synchronised
    reg [1:0] pin_s1_q;
    reg [1:0] pin_s2_q;
    reg [4:0] src_s1_q;
    reg [4:0] src_s2_q;
    reg [2:0] strap_s1_q;
    reg [2:0] strap_s2_q;
    reg pd_s1_q;
    reg pd_s2_q;

    always @(posedge CORE_CLK) begin
        if (RST) begin
            pin_s1_q <= 2'h3;
            pin_s2_q <= 2'h3;
            src_s1_q <= 5'h00;
            src_s2_q <= 5'h00;
            strap_s1_q <= 3'h0;
            strap_s2_q <= 3'h0;
            pd_s1_q <= 1'b0;
            pd_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= {pin_s1_q[0], RESET_PIN_N}; // [R14]
            pin_s2_q <= pin_s1_q;
            src_s1_q <= {POR_DET, BROWNOUT_DET, WATCHDOG_TIMER_TIMEOUT, WAKEUP_EVENT, 1'b0};
            src_s2_q <= src_s1_q;
            strap_s1_q <= {BOOT_MODE_PIN, JTAG_TMS, CLOCK_OUT_BOOT_STRAP};
            strap_s2_q <= strap_s1_q;
            pd_s1_q <= POWERDOWN_REQ;
            pd_s2_q <= pd_s1_q;
        end
    end

    wire pin_n_sync = pin_s2_q[1];
    wire por_s = src_s2_q[4];
    wire brown_s = src_s2_q[3];
    wire wdog_s = src_s2_q[2];
    wire wake_s = src_s2_q[1];

    // pin must stay low for the minimum width before it counts; shorter glitches are ignored
    reg [3:0] low_cnt_q;
    reg [3:0] low_cnt_d;
    reg pin_rst_q;
    always @* begin
        low_cnt_d = low_cnt_q;
        if (pin_n_sync)
            low_cnt_d = 4'h0;
        else if (low_cnt_q != 4'hf)
            low_cnt_d = low_cnt_q + 4'h1;
    end

    // next cause: power-on and brownout first, then pin, watchdog, wake-up
    function [2:0] pick_cause;
        input p, b, h, w, k;
        begin
            if (p)
                pick_cause = `RBS_CAUSE_POR; // [R14]
            else if (b)
                pick_cause = `RBS_CAUSE_BROWN; // [R14]
            else if (h)
                pick_cause = `RBS_CAUSE_PIN;
            else if (w)
                pick_cause = `RBS_CAUSE_WDOG;
            else if (k)
                pick_cause = `RBS_CAUSE_WAKE;
            else
                pick_cause = `RBS_CAUSE_NONE;
        end
    endfunction

    // wake-up only counts as a reset source while the device is powered down
    wire [2:0] cause_now = pick_cause(por_s, brown_s, pin_rst_q, wdog_s,
        wake_s & pd_s2_q); // [R01] [R09] [R10]

    // start mode decode; invalid strap combinations fall back to user mode and are flagged
    function [2:0] decode_mode;
        input [2:0] s;
        input prot;
        begin
            case (s[2:1])
                2'b10: decode_mode = {1'b0, `RBS_MODE_USER}; // [R04]
                2'b00: decode_mode = {1'b0, `RBS_MODE_LOADER}; // [R05]
                2'b01: begin
                    if (!s[0] && !prot)
                        decode_mode = {1'b0, `RBS_MODE_DEBUG}; // [R06]
                    else
                        decode_mode = {1'b1, `RBS_MODE_USER};
                end
                2'b11: begin
                    if (!s[0])
                        decode_mode = {1'b0, `RBS_MODE_HOTJTAG}; // [R07]
                    else
                        decode_mode = {1'b1, `RBS_MODE_USER};
                end
                default: decode_mode = {1'b1, `RBS_MODE_USER};
            endcase
        end
    endfunction

    // power-on and brownout leave the static RAM unreliable
    function is_cold;
        input [2:0] c;
        begin
            is_cold = (c == `RBS_CAUSE_POR) || (c == `RBS_CAUSE_BROWN);
        end
    endfunction

    // only power-on and pin resets may take a new boot choice
    function takes_straps;
        input [2:0] c;
        begin
            takes_straps = (c == `RBS_CAUSE_POR) || (c == `RBS_CAUSE_PIN);
        end
    endfunction

    localparam ST_RUN = 2'h0;
    localparam ST_HOLD = 2'h1;
    localparam ST_REL = 2'h2;

    reg [1:0] st_q;
    reg [1:0] st_d;
    reg [3:0] hold_q;
    reg [3:0] hold_d;
    reg [2:0] cause_q;
    reg [2:0] cause_d;
    reg pd_q;
    reg pd_d;
    wire [2:0] dec = decode_mode(strap_s2_q, FLASH_PROTECTED); // [R03]
    wire strap_cause = takes_straps(cause_q);

    // a higher source arriving during hold upgrades the cause
    function [2:0] rank;
        input [2:0] c;
        begin
            case (c)
                `RBS_CAUSE_POR: rank = 3'h5;
                `RBS_CAUSE_BROWN: rank = 3'h4;
                `RBS_CAUSE_PIN: rank = 3'h3;
                `RBS_CAUSE_WDOG: rank = 3'h2;
                `RBS_CAUSE_WAKE: rank = 3'h1;
                default: rank = 3'h0;
            endcase
        end
    endfunction

    always @* begin
        st_d = st_q;
        hold_d = hold_q;
        cause_d = cause_q;
        pd_d = pd_q;
        case (st_q)
            ST_RUN: begin
                pd_d = pd_s2_q;
                if (cause_now != `RBS_CAUSE_NONE) begin
                    st_d = ST_HOLD;
                    cause_d = cause_now;
                    hold_d = `RBS_HOLD_CYC;
                end
            end
            ST_HOLD: begin
                if (cause_now != `RBS_CAUSE_NONE) begin
                    hold_d = `RBS_HOLD_CYC;
                    if (rank(cause_now) > rank(cause_q))
                        cause_d = cause_now; // [R14]
                end else if (hold_q == 4'h0) begin
                    st_d = ST_REL;
                end else begin
                    hold_d = hold_q - 4'h1;
                end
            end
            ST_REL: begin
                st_d = ST_RUN;
                pd_d = 1'b0;
            end
            default: st_d = ST_HOLD;
        endcase
    end

    always @(posedge CORE_CLK) begin
        if (RST) begin
            low_cnt_q <= 4'h0;
            pin_rst_q <= 1'b0;
            st_q <= ST_HOLD;
            hold_q <= `RBS_HOLD_CYC;
            cause_q <= `RBS_CAUSE_POR;
            pd_q <= 1'b0;
            SYS_RESET <= 1'b1;
            RESET_CAUSE <= `RBS_CAUSE_POR;
            OSC_PLL_RESET <= 1'b1;
        end else begin
            low_cnt_q <= low_cnt_d;
            pin_rst_q <= (low_cnt_d >= `RBS_PIN_LOW_CYC); // [R08] [R09]
            st_q <= st_d;
            hold_q <= hold_d;
            cause_q <= cause_d;
            pd_q <= pd_d;
            SYS_RESET <= (st_d != ST_RUN); // [R10]
            RESET_CAUSE <= cause_d;
            // watchdog leaves the oscillator and PLL running
            OSC_PLL_RESET <= (st_d != ST_RUN) && (cause_d != `RBS_CAUSE_WDOG);
        end
    end

    // the low-power regulator never drops, so the core is supplied in every state
    always @(posedge CORE_CLK) begin
        if (RST) begin
            MAIN_REG_EN <= 1'b1;
            LP_REG_EN <= 1'b1;
        end else begin
            LP_REG_EN <= 1'b1; // [R13]
            if (st_d == ST_RUN)
                MAIN_REG_EN <= !pd_d; // [R13]
            else if (cause_d != `RBS_CAUSE_WDOG)
                MAIN_REG_EN <= 1'b1; // [R12]
            // a watchdog reset keeps whatever state the regulator had
        end
    end

    // contents are flagged unreliable while a cold reset is held
    always @(posedge CORE_CLK) begin
        if (RST) begin
            RAM_CONTENT_VALID <= 1'b0;
        end else if (st_q == ST_HOLD) begin
            if (is_cold(cause_q))
                RAM_CONTENT_VALID <= 1'b0; // [R11]
        end else if (st_q == ST_REL) begin
            RAM_CONTENT_VALID <= 1'b1;
        end
    end

    // boot choice only moves on the release of a power-on or pin reset
    always @(posedge CORE_CLK) begin
        if (RST) begin
            START_MODE <= `RBS_MODE_USER;
            STRAP_INVALID <= 1'b0;
            JTAG_PINS_ACTIVE <= 1'b0;
            PC_START <= `RBS_PC_START;
        end else if (st_q == ST_REL && strap_cause) begin
            START_MODE <= dec[1:0]; // [R02] [R03]
            STRAP_INVALID <= dec[2];
            JTAG_PINS_ACTIVE <= (dec[1:0] == `RBS_MODE_HOTJTAG) ||
                (dec[1:0] == `RBS_MODE_DEBUG); // [R07]
            PC_START <= `RBS_PC_START; // [R04] [R05]
        end
    end

endmodule

// ### testbench/rbs_asserts.sv
`timescale 1ns/10ps
module rbs_asserts (
    // clock, reset and sources
    input wire logic CORE_CLK, RST, POR_DET, RESET_PIN_N, WATCHDOG_TIMER_TIMEOUT, POWERDOWN_REQ,
    // outputs watched
    input wire logic SYS_RESET, MAIN_REG_EN, LP_REG_EN, JTAG_PINS_ACTIVE,
    input wire logic [2:0] RESET_CAUSE,
    input wire logic [1:0] START_MODE,
    input wire logic [15:0] PC_START
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    a_pin_reset_seen: assert property (!RESET_PIN_N [*3] |-> ##[0:5] SYS_RESET)
        else $error("pin low without device reset");
    a_wdog_full_reset: assert property ($rose(WATCHDOG_TIMER_TIMEOUT) |-> ##[1:6] SYS_RESET)
        else $error("watchdog timeout without device reset");
    a_por_takes_lead: assert property (POR_DET [*4] |-> ##[0:4] (SYS_RESET && RESET_CAUSE == 3'h1))
        else $error("power-on cause not reported");
    a_main_reg_off: assert property ((POWERDOWN_REQ && !SYS_RESET) [*4] |-> !MAIN_REG_EN)
        else $error("main regulator on in power-down");
    a_wdog_reg_kept: assert property (SYS_RESET && RESET_CAUSE == 3'h3 && $past(RESET_CAUSE) == 3'h3
        |-> $stable(MAIN_REG_EN))
        else $error("watchdog reset changed regulator");
    a_boot_held: assert property (!SYS_RESET && !$past(SYS_RESET)
        |-> $stable(START_MODE) && $stable(JTAG_PINS_ACTIVE))
        else $error("start mode changed outside reset");
    a_jtag_mode_pins: assert property (JTAG_PINS_ACTIVE == START_MODE[1])
        else $error("jtag pins disagree with mode");
    a_lp_reg_pc: assert property (LP_REG_EN && PC_START == 16'h0000)
        else $error("low-power regulator off or start address wrong");
    a_wake_reg_on: assert property (SYS_RESET && RESET_CAUSE == 3'h4 |-> MAIN_REG_EN)
        else $error("wake-up reset left main regulator off");
    cover property ($fell(SYS_RESET));
    cover property (SYS_RESET && RESET_CAUSE == 3'h4);
    cover property (!SYS_RESET && START_MODE == 2'h2);
endmodule

// ### testbench/rbs_board.sv
`timescale 1ns/10ps
module rbs_board #(parameter int LOW_NS = 150) (
    // requests from the bench
    input wire logic PIN_REQ,
    input wire logic [2:0] STRAP,
    // board pins
    output logic RESET_PIN_N,
    output wire logic BOOT_MODE_PIN,
    output wire logic JTAG_TMS,
    output wire logic CLOCK_OUT_BOOT_STRAP
);
    initial RESET_PIN_N = 1'b1;
    // straps always at a defined level, never floating
    assign {BOOT_MODE_PIN, JTAG_TMS, CLOCK_OUT_BOOT_STRAP} = STRAP;
    // pull-up returns the pin high; a short request still gets the minimum low time
    always @(posedge PIN_REQ) begin
        RESET_PIN_N = 1'b0;
        #LOW_NS;
        wait (!PIN_REQ);
        RESET_PIN_N = 1'b1;
    end
endmodule

// ### testbench/tb_reset_and_boot_select.sv
`timescale 1ns/10ps
`include "rbs_map.vh"
module tb_reset_and_boot_select;
    logic clk = 0, rst = 1, por = 0, wdog = 0, wake = 0, brown = 0, pd = 0, prot = 0, preq = 0;
    logic last = 1, ram_low = 0, osc_seen = 0;
    logic [6:0] note;
    wire ram, osc;
    wire [15:0] pc;
    logic [2:0] strap = 3'h4;
    logic [3:0] cur;
    logic [6:0] q[$];
    int err_count = 0, n_tests = 0;
    wire pin_n, bm, tms, co, sr, mreg, lreg, jtag, inv;
    wire [2:0] cause;
    wire [1:0] mode;
    rbs_board i_board (.PIN_REQ(preq), .STRAP(strap), .RESET_PIN_N(pin_n),
        .BOOT_MODE_PIN(bm), .JTAG_TMS(tms), .CLOCK_OUT_BOOT_STRAP(co));
    rbs_reset_boot i_dut (.CORE_CLK(clk), .RST(rst), .POR_DET(por), .RESET_PIN_N(pin_n),
        .WATCHDOG_TIMER_TIMEOUT(wdog), .WAKEUP_EVENT(wake), .BROWNOUT_DET(brown),
        .POWERDOWN_REQ(pd), .BOOT_MODE_PIN(bm), .JTAG_TMS(tms), .CLOCK_OUT_BOOT_STRAP(co),
        .FLASH_PROTECTED(prot), .SYS_RESET(sr), .RESET_CAUSE(cause), .RAM_CONTENT_VALID(ram),
        .OSC_PLL_RESET(osc), .MAIN_REG_EN(mreg), .LP_REG_EN(lreg), .START_MODE(mode),
        .STRAP_INVALID(inv), .JTAG_PINS_ACTIVE(jtag), .PC_START(pc));
    initial forever #25 clk = ~clk;

    task automatic chk(input string nm, input logic [6:0] e, input logic [6:0] s);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    // {mode, jtag, invalid} for a strap set {boot, tms, strap}
    function automatic logic [3:0] bootv(input logic [2:0] s, input logic p);
        logic [1:0] m;
        logic iv;
        m = `RBS_MODE_USER;
        iv = 1'b0;
        if (!s[1]) m = s[2] ? `RBS_MODE_USER : `RBS_MODE_LOADER;
        else if (s[0]) iv = 1'b1;
        else if (s[2]) m = `RBS_MODE_HOTJTAG;
        else if (p) iv = 1'b1;
        else m = `RBS_MODE_DEBUG;
        return {m, m[1], iv};
    endfunction

    // only power-on and pin resets take a new boot choice
    task automatic fire(input logic [2:0] c);
        int n;
        if (c == `RBS_CAUSE_PIN || c == `RBS_CAUSE_POR) cur = bootv(strap, prot);
        q.push_back({c, cur});
        case (c)
            `RBS_CAUSE_PIN: preq = 1;
            `RBS_CAUSE_WDOG: wdog = 1;
            `RBS_CAUSE_WAKE: wake = 1;
            `RBS_CAUSE_BROWN: brown = 1;
            default: por = 1;
        endcase
        repeat (5) @(negedge clk);
        {preq, wdog, wake, brown, por, pd} = 6'h0;
        n = 0;
        while ((sr || q.size() != 0) && n < 80) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic stop_test();
        if (q.size() != 0) err_count++;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // each release of the internal reset must match the oldest note
    always @(negedge clk) begin
        if (sr) begin
            ram_low = ram_low | !ram;
            osc_seen = osc_seen | osc;
        end
        if (last && !sr && !rst) begin
            if (q.size() == 0) begin
                chk("spurious reset", 7'h0, 7'h7f);
            end else begin
                note = q.pop_front();
                chk("cause and boot", note, {cause, mode, jtag, inv});
                chk("ram lost", {6'h0, note[6:4] == `RBS_CAUSE_POR ||
                    note[6:4] == `RBS_CAUSE_BROWN}, {6'h0, ram_low});
                chk("osc reset", {6'h0, note[6:4] != `RBS_CAUSE_WDOG}, {6'h0, osc_seen});
                chk("pc start", 7'h0, {6'h0, |pc});
            end
            ram_low = 0;
            osc_seen = 0;
        end
        last = sr;
    end

    initial begin
        void'($urandom(41));
        cur = bootv(strap, prot);
        q.push_back({`RBS_CAUSE_POR, cur});
        repeat (10) @(negedge clk);
        rst = 0;
        repeat (20) @(negedge clk);
        for (int i = 0; i < 16; i++) begin
            strap = i[2:0];
            prot = i[3];
            fire(`RBS_CAUSE_PIN);
        end
        $display("boot table done");
        strap = 3'($urandom);
        fire(`RBS_CAUSE_WDOG);
        $display("watchdog done");
        pd = 1;
        repeat (6) @(negedge clk);
        chk("main regulator", 7'h0, {6'h0, mreg});
        chk("lp regulator", 7'h1, {6'h0, lreg});
        fire(`RBS_CAUSE_WAKE);
        chk("main regulator", 7'h1, {6'h0, mreg});
        pd = 1;
        repeat (6) @(negedge clk);
        fire(`RBS_CAUSE_PIN);
        fire(`RBS_CAUSE_BROWN);
        preq = 1;
        fire(`RBS_CAUSE_POR);
        $display("power and priority done");
        stop_test();
    end

    initial begin
        #100us;
        err_count++;
        stop_test();
    end
endmodule

bind rbs_reset_boot rbs_asserts i_chk (.CORE_CLK(CORE_CLK), .RST(RST), .POR_DET(POR_DET),
    .RESET_PIN_N(RESET_PIN_N), .WATCHDOG_TIMER_TIMEOUT(WATCHDOG_TIMER_TIMEOUT),
    .POWERDOWN_REQ(POWERDOWN_REQ), .SYS_RESET(SYS_RESET), .MAIN_REG_EN(MAIN_REG_EN),
    .LP_REG_EN(LP_REG_EN), .JTAG_PINS_ACTIVE(JTAG_PINS_ACTIVE), .RESET_CAUSE(RESET_CAUSE),
    .START_MODE(START_MODE), .PC_START(PC_START));
